// *** vms_bus_port.v ***
`timescale 1ns/1ps
module vms_bus_port (
    clk,
    rst_n,
    ad_in,
    ale,
    rd_n,
    wr_n,
    cs,
    addr,
    wdata,
    wr_stb,
    rd_end,
    rd_act
);
    input wire clk;
    input wire rst_n;
    input wire [7:0] ad_in;
    input wire ale;
    input wire rd_n;
    input wire wr_n;
    input wire cs;
    output wire [7:0] addr;
    output wire [7:0] wdata;
    output wire wr_stb;
    output wire rd_end;
    output wire rd_act;

    reg ale_d_ff;
    reg wr_d_ff;
    reg rd_d_ff;
    reg [7:0] addr_ff;
    reg [7:0] wdata_ff;
    reg wr_stb_ff;
    reg rd_end_ff;
    reg rd_act_ff;

    // ****************************************
    // Address latch and strobes
    // ****************************************
    // Write is taken at the end of the strobe, when data is settled
    always @(posedge clk) begin
        if (!rst_n) begin
            ale_d_ff <= 1'b0;
            wr_d_ff <= 1'b1;
            rd_d_ff <= 1'b1;
            addr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wr_stb_ff <= 1'b0;
            rd_end_ff <= 1'b0;
            rd_act_ff <= 1'b0;
        end else begin
            ale_d_ff <= ale;
            wr_d_ff <= wr_n;
            rd_d_ff <= rd_n;
            if (ale_d_ff && !ale) begin
                addr_ff <= ad_in;
            end
            if (!wr_n) begin
                wdata_ff <= ad_in;
            end
            wr_stb_ff <= cs && !wr_d_ff && wr_n;
            rd_end_ff <= cs && !rd_d_ff && rd_n;
            rd_act_ff <= cs && !rd_n;
        end
    end

    assign addr = addr_ff;
    assign wdata = wdata_ff;
    assign wr_stb = wr_stb_ff;
    assign rd_end = rd_end_ff;
    assign rd_act = rd_act_ff;
endmodule // vms_bus_port

// *** vms_consts.vh ***
`ifndef VMS_CONSTS_VH
`define VMS_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define VMS_OFF_TXCTL 8'h01
`define VMS_OFF_CMD 8'h03
`define VMS_OFF_TXSTAT 8'h05
`define VMS_OFF_LASTERR 8'h07
`define VMS_OFF_IRQ 8'h09
`define VMS_OFF_CHAN 8'h10
`define VMS_CHAN_MASK 8'hF8

// ****************************************
// Channel flag fields
// ****************************************
`define VMS_CH_SENT 0
`define VMS_CH_GOT 1
`define VMS_CH_RTR 2
`define VMS_CH_RNW 3
`define VMS_CH_ABORT 4

// ****************************************
// Command fields and reset values
// ****************************************
`define VMS_CMD_GO_ACTIVE_BIT 0
`define VMS_CMD_IDLE 1
`define VMS_CMD_SLEEP 2
`define VMS_CMD_REARB 3
`define VMS_CMD_RESET 8'h02
`define VMS_TXCTL_RESET 8'h00

// ****************************************
// Status fields
// ****************************************
`define VMS_ERR_CV 0
`define VMS_ERR_ACKNOWLEDGE_FAILURE_FLAG 1
`define VMS_ERR_FRAME_CHECK_FAILURE_FLAG 2
`define VMS_IRQ_TE 0
`define VMS_IRQ_RXOK 1
`define VMS_IRQ_TXOK 2

// ****************************************
// Frame kinds
// ****************************************
`define VMS_KIND_DATA 2'h0
`define VMS_KIND_RREQ 2'h1
`define VMS_KIND_DEFER 2'h2

`endif

// *** vms_line_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Line engine standing for the far nodes
// ****************************************
module vms_line_model (
    input wire clk,
    input wire rst_n,
    input wire tx_req,
    input wire [2:0] tx_chan,
    input wire [1:0] tx_kind,
    input wire [2:0] bad_ch,
    input wire [2:0] bad_how,
    input wire lose_first,
    output reg att_done,
    output reg att_ok,
    output reg att_lost,
    output reg att_cv,
    output reg att_acknowledge_failure_flag,
    output reg att_frame_check_failure_flag,
    output reg att_inframe
);
    reg [7:0] cnt [0:7];
    reg [1:0] kind_seen [0:7];
    reg [3:0] first_ch;
    reg [2:0] wait_ff;
    reg busy;
    reg lose;
    reg [31:0] rnd;
    integer seed;
    integer i;
    initial seed = 56451;
    always @(posedge clk) begin
        rnd = $random(seed);
        lose = lose_first && tx_chan == bad_ch && cnt[tx_chan] == 8'h00;
        // Qualifiers carry noise outside the done pulse
        {att_ok, att_lost, att_cv, att_acknowledge_failure_flag, att_frame_check_failure_flag, att_inframe} <= rnd[5:0];
        att_done <= 1'b0;
        if (!rst_n) begin
            busy <= 1'b0;
            first_ch <= 4'h8;
            for (i = 0; i < 8; i = i + 1) cnt[i] <= 8'h00;
        end else if (tx_req && !busy && !att_done) begin
            busy <= 1'b1;
            // Random wait gives prompt and slow answers
            wait_ff <= rnd[8:6];
        end else if (busy && wait_ff != 3'h0) begin
            wait_ff <= wait_ff - 3'h1;
        end else if (busy) begin
            busy <= 1'b0;
            att_done <= 1'b1;
            att_lost <= lose;
            att_ok <= !lose && tx_chan != bad_ch;
            {att_frame_check_failure_flag, att_acknowledge_failure_flag, att_cv} <= (!lose && tx_chan == bad_ch) ? bad_how : 3'h0;
            att_inframe <= 1'b0;
            cnt[tx_chan] <= cnt[tx_chan] + 8'h01;
            kind_seen[tx_chan] <= tx_kind;
            if (first_ch == 4'h8) first_ch <= {1'b0, tx_chan};
        end
    end
endmodule // vms_line_model

// *** vms_scheduler.v ***
`timescale 1ns/1ps
`include "vms_consts.vh"

module vms_scheduler (
    clk,
    rst_n,
    ad_in,
    ale,
    rd_n,
    wr_n,
    cs,
    ad_out,
    ad_oe_n,
    att_done,
    att_ok,
    att_lost,
    att_cv,
    att_acknowledge_failure_flag,
    att_frame_check_failure_flag,
    att_inframe,
    rx_evt,
    rx_kind,
    rx_match,
    tx_req,
    tx_chan,
    tx_kind,
    reply_arm,
    line_en,
    txd_oe_n,
    osc_run
);
    input wire clk;
    input wire rst_n;
    input wire [7:0] ad_in;
    input wire ale;
    input wire rd_n;
    input wire wr_n;
    input wire cs;
    output reg [7:0] ad_out;
    output reg ad_oe_n;
    input wire att_done;
    input wire att_ok;
    input wire att_lost;
    input wire att_cv;
    input wire att_acknowledge_failure_flag;
    input wire att_frame_check_failure_flag;
    input wire att_inframe;
    input wire rx_evt;
    input wire [1:0] rx_kind;
    input wire [7:0] rx_match;
    output reg tx_req;
    output reg [2:0] tx_chan;
    output reg [1:0] tx_kind;
    output reg [7:0] reply_arm;
    output reg line_en;
    output reg txd_oe_n;
    output reg osc_run;

    localparam [2:0] MODE_IDLE = 3'b001;
    localparam [2:0] MODE_ACTIVE = 3'b010;
    localparam [2:0] MODE_SLEEP = 3'b100;

    wire [7:0] addr;
    wire [7:0] wdata;
    wire wr_stb;
    wire rd_end;
    wire rd_act;

    reg [4:0] ch_ff [0:7];
    reg [4:0] nxt_ch [0:7];
    reg [7:0] stop_ff;
    reg [7:0] nxt_stop;
    reg [7:0] txctl_ff;
    reg [7:0] cmd_ff;
    reg [7:0] nxt_cmd;
    reg [2:0] errs_ff;
    reg [2:0] irq_ff;
    reg [2:0] nxt_irq;
    reg [2:0] mode_ff;
    reg [2:0] nxt_mode;
    reg busy_ff;
    reg own_v_ff;
    reg [2:0] own_ff;
    reg post_v_ff;
    reg [2:0] post_ff;
    reg [3:0] cnt_ff;
    reg [3:0] retries_ff;
    reg [7:0] rdata;
    reg [7:0] elig;
    reg [7:0] rx_take;
    reg [7:0] higher;
    reg [3:0] pick;
    reg [3:0] hpick;
    reg [3:0] rpick;
    integer i;
    integer j;
    integer n;

    vms_bus_port u_port (
        .clk(clk),
        .rst_n(rst_n),
        .ad_in(ad_in),
        .ale(ale),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .cs(cs),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_end(rd_end),
        .rd_act(rd_act)
    );

    // ****************************************
    // Channel type decoding
    // ****************************************
    // Inactive types never transmit
    function can_send;
        input [4:0] f;
        input stopped;
        begin
            can_send = !f[`VMS_CH_SENT] && !stopped &&
                ((!f[`VMS_CH_RNW] && !f[`VMS_CH_RTR]) || (f[`VMS_CH_RNW] && f[`VMS_CH_RTR]) ||
                 (f[`VMS_CH_RNW] && !f[`VMS_CH_RTR] && f[`VMS_CH_GOT]));
        end
    endfunction

    // Lowest index wins; bit 3 set when found
    function [3:0] lowest;
        input [7:0] m;
        integer k;
        begin
            lowest = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (m[k]) begin
                    lowest = {1'b1, k[2:0]};
                end
            end
        end
    endfunction

    function [1:0] kind_of;
        input [4:0] f;
        begin
            if (!f[`VMS_CH_RNW]) begin
                kind_of = `VMS_KIND_DATA;
            end else if (f[`VMS_CH_RTR]) begin
                kind_of = `VMS_KIND_RREQ;
            end else begin
                kind_of = `VMS_KIND_DEFER;
            end
        end
    endfunction

    // ****************************************
    // Receive selection and flag updates
    // ****************************************
    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            elig[i] = can_send(ch_ff[i], stop_ff[i]);
            higher[i] = elig[i] && (i < own_ff);
            case (rx_kind)
                `VMS_KIND_DATA: begin
                    rx_take[i] = !ch_ff[i][`VMS_CH_RNW] && ch_ff[i][`VMS_CH_RTR] && !ch_ff[i][`VMS_CH_GOT];
                end
                `VMS_KIND_DEFER: begin
                    rx_take[i] = ch_ff[i][3:0] == 4'hD;
                end
                `VMS_KIND_RREQ: begin
                    rx_take[i] = ch_ff[i][`VMS_CH_RNW] && !ch_ff[i][`VMS_CH_RTR] && !ch_ff[i][`VMS_CH_GOT];
                end
                default: begin
                    rx_take[i] = 1'b0;
                end
            endcase
        end
        pick = lowest(elig);
        hpick = lowest(higher);
        rpick = lowest(rx_take & rx_match);
        nxt_stop = stop_ff;
        nxt_irq = irq_ff;
        nxt_cmd = cmd_ff;
        if (rd_end && addr == `VMS_OFF_IRQ) begin
            nxt_irq = 3'h0;
        end
        if (wr_stb && addr == `VMS_OFF_CMD) begin
            nxt_cmd = wdata;
            if (wdata[`VMS_CMD_IDLE] || wdata[`VMS_CMD_GO_ACTIVE_BIT]) begin
                nxt_cmd[`VMS_CMD_SLEEP] = 1'b0;
            end
        end
        for (i = 0; i < 8; i = i + 1) begin
            nxt_ch[i] = ch_ff[i];
            if (wr_stb && addr == (`VMS_OFF_CHAN | i[7:0])) begin
                nxt_ch[i] = wdata[4:0];
                if (!wdata[`VMS_CH_SENT]) begin
                    nxt_stop[i] = 1'b0;
                end
            end
            // Abort acts unless the channel is mid attempt
            if (ch_ff[i][`VMS_CH_ABORT] && !(busy_ff && own_ff == i)) begin
                nxt_ch[i][`VMS_CH_ABORT] = 1'b0;
                nxt_ch[i][`VMS_CH_SENT] = 1'b1;
            end
        end
        // Only the lowest matching channel is updated
        if (rx_evt && rpick[3]) begin
            nxt_irq[`VMS_IRQ_RXOK] = 1'b1;
            // Immediate reply also marks sent; detection only got
            if (rx_kind == `VMS_KIND_RREQ && !ch_ff[rpick[2:0]][`VMS_CH_SENT]) begin
                nxt_ch[rpick[2:0]][`VMS_CH_SENT] = 1'b1;
            end
            nxt_ch[rpick[2:0]][`VMS_CH_GOT] = 1'b1;
        end
        // Attempt results only concern our own frame
        if (att_done && busy_ff) begin
            if (att_ok) begin
                nxt_irq[`VMS_IRQ_TXOK] = 1'b1;
                // Deferred and plain frames set sent only
                nxt_ch[own_ff][`VMS_CH_SENT] = 1'b1;
                nxt_ch[own_ff][`VMS_CH_ABORT] = 1'b0;
                // In-frame reply sets both flags; occupied buffer kept
                if (att_inframe && kind_of(ch_ff[own_ff]) == `VMS_KIND_RREQ) begin
                    nxt_ch[own_ff][`VMS_CH_GOT] = 1'b1;
                end
            end else if (!att_lost) begin
                // Pending abort lands when the attempt fails
                if (ch_ff[own_ff][`VMS_CH_ABORT]) begin
                    nxt_ch[own_ff][`VMS_CH_ABORT] = 1'b0;
                    nxt_ch[own_ff][`VMS_CH_SENT] = 1'b1;
                end
                if (cnt_ff == 4'h0) begin
                    nxt_irq[`VMS_IRQ_TE] = 1'b1;
                    nxt_stop[own_ff] = 1'b1;
                end
            end
        end
        // Rearbitrate cleared at the first pause with an owner, whether or not a handover is taken
        if (!busy_ff && own_v_ff && cmd_ff[`VMS_CMD_REARB]) begin
            nxt_cmd[`VMS_CMD_REARB] = 1'b0;
        end
        // Sleep wins; activate with idle clear
        case (mode_ff)
            MODE_IDLE, MODE_ACTIVE, MODE_SLEEP: begin
                if (cmd_ff[`VMS_CMD_SLEEP]) begin
                    nxt_mode = MODE_SLEEP;
                end else if (cmd_ff[`VMS_CMD_IDLE]) begin
                    // Idle only once attempts have drained
                    nxt_mode = (mode_ff == MODE_ACTIVE && (busy_ff || own_v_ff || post_v_ff)) ? MODE_ACTIVE : MODE_IDLE;
                end else if (cmd_ff[`VMS_CMD_GO_ACTIVE_BIT]) begin
                    nxt_mode = MODE_ACTIVE;
                end else begin
                    nxt_mode = mode_ff;
                end
            end
            default: begin
                nxt_mode = MODE_IDLE;
            end
        endcase
    end

    // ****************************************
    // State registers
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            for (j = 0; j < 8; j = j + 1) begin
                ch_ff[j] <= 5'h03;
            end
            stop_ff <= 8'h00;
            txctl_ff <= `VMS_TXCTL_RESET;
            cmd_ff <= `VMS_CMD_RESET;
            irq_ff <= 3'h0;
            errs_ff <= 3'h0;
            mode_ff <= MODE_IDLE;
        end else begin
            for (j = 0; j < 8; j = j + 1) begin
                ch_ff[j] <= nxt_ch[j];
            end
            stop_ff <= nxt_stop;
            cmd_ff <= nxt_cmd;
            irq_ff <= nxt_irq;
            mode_ff <= nxt_mode;
            if (wr_stb && addr == `VMS_OFF_TXCTL) begin
                txctl_ff <= wdata;
            end
            // Only real failures update the cause
            if (att_done && busy_ff && !att_ok && !att_lost) begin
                errs_ff <= {att_frame_check_failure_flag, att_acknowledge_failure_flag, att_cv};
            end
        end
    end

    // ****************************************
    // Transmit scheduler
    // ****************************************
    // Channel keeps ownership across retries so a new lower channel waits its turn
    always @(posedge clk) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
            own_v_ff <= 1'b0;
            own_ff <= 3'h0;
            post_v_ff <= 1'b0;
            post_ff <= 3'h0;
            cnt_ff <= 4'h0;
            retries_ff <= 4'h0;
        end else if (busy_ff) begin
            if (att_done) begin
                busy_ff <= 1'b0;
                // Lost contention leaves the counter alone
                if (att_ok || (!att_lost && (cnt_ff == 4'h0 || ch_ff[own_ff][`VMS_CH_ABORT]))) begin
                    own_v_ff <= 1'b0;
                end else if (!att_lost) begin
                    // Load of N allows N further attempts
                    cnt_ff <= cnt_ff - 4'h1;
                    retries_ff <= retries_ff + 4'h1;
                end
            end
        end else if (own_v_ff && !elig[own_ff]) begin
            own_v_ff <= 1'b0;
        end else if (own_v_ff && cmd_ff[`VMS_CMD_REARB]) begin
            // Postpone owner, hand to higher channel with fresh count
            if (hpick[3]) begin
                post_v_ff <= 1'b1;
                post_ff <= own_ff;
                own_ff <= hpick[2:0];
                cnt_ff <= txctl_ff[3:0];
                retries_ff <= 4'h0;
            end
        end else if (mode_ff == MODE_ACTIVE) begin
            if (own_v_ff) begin
                busy_ff <= 1'b1;
            end else if (post_v_ff) begin
                // Resume postponed only while still enabled
                post_v_ff <= 1'b0;
                if (elig[post_ff]) begin
                    own_v_ff <= 1'b1;
                    own_ff <= post_ff;
                    cnt_ff <= txctl_ff[3:0];
                    retries_ff <= 4'h0;
                end
            end else if (pick[3]) begin
                // Lowest ready channel; shared counter load
                own_v_ff <= 1'b1;
                own_ff <= pick[2:0];
                cnt_ff <= txctl_ff[3:0];
                retries_ff <= 4'h0;
            end
        end
    end

    // ****************************************
    // Read data and pins
    // ****************************************
    always @* begin
        rdata = 8'h00;
        if ((addr & `VMS_CHAN_MASK) == `VMS_OFF_CHAN) begin
            rdata = {3'h0, ch_ff[addr[2:0]]};
        end else begin
            case (addr)
                `VMS_OFF_TXCTL: rdata = txctl_ff;
                `VMS_OFF_CMD: rdata = cmd_ff;
                `VMS_OFF_TXSTAT: rdata = {retries_ff, own_v_ff, own_ff};
                `VMS_OFF_LASTERR: rdata = {5'h00, errs_ff};
                `VMS_OFF_IRQ: rdata = {5'h00, irq_ff};
                default: rdata = 8'h00;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            ad_out <= 8'h00;
            ad_oe_n <= 1'b1;
            tx_req <= 1'b0;
            tx_chan <= 3'h0;
            tx_kind <= 2'h0;
            reply_arm <= 8'h00;
            line_en <= 1'b0;
            txd_oe_n <= 1'b1;
            osc_run <= 1'b1;
        end else begin
            ad_out <= rdata;
            ad_oe_n <= !rd_act;
            tx_req <= busy_ff && !att_done;
            tx_chan <= own_ff;
            tx_kind <= kind_of(ch_ff[own_ff]);
            for (n = 0; n < 8; n = n + 1) begin
                reply_arm[n] <= mode_ff == MODE_ACTIVE && ch_ff[n][3:0] == 4'h8;
            end
            // Idle and sleep keep the line released
            line_en <= mode_ff == MODE_ACTIVE;
            txd_oe_n <= mode_ff != MODE_ACTIVE;
            osc_run <= mode_ff != MODE_SLEEP;
        end
    end
endmodule // vms_scheduler

// *** vms_scheduler_chk.sv ***
`timescale 1ns/1ps
// ****************************************
// Port checks of the scheduler
// ****************************************
module vms_scheduler_chk (
    input logic clk,
    input logic rst_n,
    input logic rd_n,
    input logic cs,
    input logic ad_oe_n,
    input logic att_done,
    input logic tx_req,
    input logic [2:0] tx_chan,
    input logic [1:0] tx_kind,
    input logic line_en,
    input logic txd_oe_n,
    input logic osc_run
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Read strobe held long enough for the two stage lag
    sequence s_rd_held;
        (cs && !rd_n) [*2];
    endsequence
    sequence s_gap;
        !tx_req [*2];
    endsequence
    chk_leave_reset: assert property ($rose(rst_n) |-> !tx_req && !line_en && txd_oe_n && osc_run)
        else $error("outputs active after reset");
    chk_idle_released: assert property (!line_en |-> txd_oe_n)
        else $error("transmit output driven while idle");
    chk_idle_no_start: assert property ($rose(tx_req) |-> line_en)
        else $error("attempt started outside active mode");
    chk_sleep_silent: assert property (!osc_run |-> !line_en && !tx_req)
        else $error("traffic while oscillator stopped");
    chk_idle_waits: assert property (tx_req && !att_done && line_en |=> line_en)
        else $error("left active mode during an attempt");
    chk_req_held: assert property (tx_req && !att_done |=> tx_req && $stable(tx_chan) && $stable(tx_kind))
        else $error("request changed during an attempt");
    chk_req_drop: assert property (tx_req && att_done |=> !tx_req)
        else $error("request kept after attempt end");
    chk_req_gap: assert property ($fell(tx_req) |-> s_gap)
        else $error("next attempt too soon");
    chk_read_drive: assert property (s_rd_held |=> !ad_oe_n)
        else $error("read data not driven");
    chk_read_release: assert property ((rd_n || !cs) [*4] |-> ad_oe_n)
        else $error("bus still driven after read");
endmodule // vms_scheduler_chk

bind vms_scheduler vms_scheduler_chk i_vms_scheduler_chk (
    .clk(clk), .rst_n(rst_n), .rd_n(rd_n), .cs(cs), .ad_oe_n(ad_oe_n), .att_done(att_done),
    .tx_req(tx_req), .tx_chan(tx_chan), .tx_kind(tx_kind), .line_en(line_en),
    .txd_oe_n(txd_oe_n), .osc_run(osc_run)
);

// *** vms_scheduler_test.sv ***
`timescale 1ns/1ps
module vms_scheduler_test;
    reg clk, rst_n, ale, rd_n, wr_n, cs, rx_evt, lose_first;
    reg [1:0] rx_kind;
    reg [2:0] bad_ch, bad_how;
    reg [3:0] mr;
    reg [7:0] tb_ad, rx_match, v;
    wire [7:0] ad_in, ad_out, reply_arm;
    wire [2:0] tx_chan;
    wire [1:0] tx_kind;
    wire ad_oe_n, tx_req, line_en, txd_oe_n, osc_run;
    wire att_done, att_ok, att_lost, att_cv, att_acknowledge_failure_flag, att_frame_check_failure_flag, att_inframe;
    integer seed, mismatches, check_count, k, i;
    // Device owns the shared bus only while it drives
    assign ad_in = ad_oe_n ? tb_ad : ad_out;
    vms_scheduler i_vms_scheduler (
        .clk(clk), .rst_n(rst_n), .ad_in(ad_in), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .cs(cs),
        .ad_out(ad_out), .ad_oe_n(ad_oe_n), .att_done(att_done), .att_ok(att_ok), .att_lost(att_lost),
        .att_cv(att_cv), .att_acknowledge_failure_flag(att_acknowledge_failure_flag), .att_frame_check_failure_flag(att_frame_check_failure_flag), .att_inframe(att_inframe),
        .rx_evt(rx_evt), .rx_kind(rx_kind), .rx_match(rx_match), .tx_req(tx_req), .tx_chan(tx_chan),
        .tx_kind(tx_kind), .reply_arm(reply_arm), .line_en(line_en), .txd_oe_n(txd_oe_n), .osc_run(osc_run)
    );
    vms_line_model i_vms_line_model (
        .clk(clk), .rst_n(rst_n), .tx_req(tx_req), .tx_chan(tx_chan), .tx_kind(tx_kind), .bad_ch(bad_ch),
        .bad_how(bad_how), .lose_first(lose_first), .att_done(att_done), .att_ok(att_ok),
        .att_lost(att_lost), .att_cv(att_cv), .att_acknowledge_failure_flag(att_acknowledge_failure_flag), .att_frame_check_failure_flag(att_frame_check_failure_flag),
        .att_inframe(att_inframe)
    );
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function [7:0] flags(input read_request_flag, input reply_wanted_flag, input sent, input got);
        flags = {4'h0, read_request_flag, reply_wanted_flag, got, sent};
    endfunction
    function [7:0] tries(input [3:0] m, input lost);
        tries = {4'h0, m} + 8'h01 + {7'h0, lost};
    endfunction
    task tick;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task check(input string nm, input [7:0] got, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                $display("mismatch %s expected %h seen %h", nm, exp, got);
                mismatches = mismatches + 1;
            end
        end
    endtask
    task addr_phase(input [7:0] a);
        begin
            tick;
            ale = 1'b1;
            cs = 1'b1;
            tb_ad = a;
            tick;
            ale = 1'b0;
            tick;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            addr_phase(a);
            wr_n = 1'b0;
            tb_ad = d;
            repeat (2) tick;
            wr_n = 1'b1;
            repeat (3) tick;
            cs = 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            addr_phase(a);
            rd_n = 1'b0;
            tb_ad = ~a;
            k = 0;
            while (ad_oe_n !== 1'b0 && k < 20) begin
                tick;
                k = k + 1;
            end
            d = (k < 20) ? ad_out : 8'hXX;
            rd_n = 1'b1;
            repeat (3) tick;
            cs = 1'b0;
        end
    endtask
    task rx(input [1:0] kd, input [7:0] m);
        begin
            tick;
            rx_evt = 1'b1;
            rx_kind = kd;
            rx_match = m;
            tick;
            rx_evt = 1'b0;
            rx_match = ~m;
            repeat (4) tick;
        end
    endtask
    task wait_cnt(input [2:0] ch);
        begin
            k = 0;
            while ((i_vms_line_model.cnt[ch] === 8'h00 || tx_req !== 1'b0) && k < 3000) begin
                tick;
                k = k + 1;
            end
            check("attempt wait", (k < 3000) ? 8'h01 : 8'h00, 8'h01);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches = mismatches + 1;
        finish_test;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 56451;
        mismatches = 0;
        check_count = 0;
        {rst_n, ale, cs, rx_evt, lose_first} = 5'h00;
        {rd_n, wr_n} = 2'h3;
        {rx_kind, bad_ch, bad_how, tb_ad, rx_match} = 24'h000000;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(8'h03, v); check("command", v, 8'h02);
        rd(8'h01, v); check("transmit control", v, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            rd(8'h10 + i[7:0], v); check("channel reset", v, flags(0, 0, 1, 1));
        end
        wr(8'h05, 8'hFF);
        rd(8'h05, v); check("progress", v, 8'h00);
        rd(8'h0B, v); check("unmapped", v, 8'h00);
        check("idle pins", {txd_oe_n, line_en, osc_run}, 8'h05);
        $display("test reset done");
        wr(8'h03, 8'h04);
        tick;
        check("sleep osc", {7'h0, osc_run}, 8'h00);
        wr(8'h03, 8'h02);
        tick;
        check("wake osc", {7'h0, osc_run}, 8'h01);
        $display("test sleep done");
        k = $random(seed);
        mr = 4'h1 + k[0] + k[1];
        bad_how = 3'h1 << (k[3:2] % 3);
        bad_ch = 3'h2;
        lose_first = 1'b1;
        wr(8'h01, {4'h0, mr});
        wr(8'h15, flags(0, 0, 0, 0));
        wr(8'h12, flags(0, 0, 0, 0));
        wr(8'h10, 8'h10);
        rd(8'h10, v); check("abort sent", v & 8'h01, 8'h01);
        check("no traffic idle", {7'h0, tx_req}, 8'h00);
        wr(8'h03, 8'h01);
        tick;
        check("active pins", {txd_oe_n, line_en}, 8'h01);
        wait_cnt(3'h5);
        check("first channel", {4'h0, i_vms_line_model.first_ch}, 8'h02);
        check("attempts", i_vms_line_model.cnt[2], tries(mr, 1'b1));
        check("next channel", i_vms_line_model.cnt[5], 8'h01);
        check("aborted quiet", i_vms_line_model.cnt[0], 8'h00);
        rd(8'h09, v); check("failure irq", v & 8'h01, 8'h01);
        rd(8'h07, v); check("failure cause", v & 8'h07, {5'h0, bad_how});
        rd(8'h15, v); check("sent flags", v, flags(0, 0, 1, 0));
        $display("test transmit done");
        bad_ch = 3'h0;
        wr(8'h14, flags(0, 1, 0, 0));
        wr(8'h16, flags(0, 1, 0, 0));
        rx(2'h0, 8'h50);
        rd(8'h14, v); check("low receiver", v, flags(0, 1, 0, 1));
        rd(8'h16, v); check("high waits", v, flags(0, 1, 0, 0));
        rx(2'h0, 8'h50);
        rd(8'h16, v); check("high receiver", v, flags(0, 1, 0, 1));
        // request frame aimed at a reply channel already sent: detection only, no reply armed
        wr(8'h13, flags(1, 0, 1, 0));
        rx(2'h1, 8'h08);
        rd(8'h13, v); check("detect flags", v, flags(1, 0, 1, 1));
        rd(8'h09, v); check("detect irq", v & 8'h02, 8'h02);
        check("detect no reply", {7'h0, reply_arm[3]}, 8'h00);
        wr(8'h11, flags(1, 0, 0, 0));
        check("reply armed", {7'h0, reply_arm[1]}, 8'h01);
        $display("test receive done");
        wr(8'h17, flags(1, 0, 0, 1));
        wait_cnt(3'h7);
        check("deferred kind", {6'h0, i_vms_line_model.kind_seen[7]}, 8'h02);
        rd(8'h17, v); check("deferred flags", v, flags(1, 0, 1, 1));
        $display("test deferred done");
        finish_test;
    end
endmodule // vms_scheduler_test
